// *** shared/cbu_pkg.sv ***
// Purpose: Shared constants for the compare, skip and branch execution unit
// Assumes: 16-bit instruction words, 8-bit data, flags held as one byte
// Notes:   Opcode field sits in bits 15:12 of the first instruction word
package cbu_pkg;

  localparam int          DATA_W      = 8;
  localparam int          INSTR_W     = 16;

  // Opcode classes (bits 15:12)
  localparam logic [3:0]  OP_CMP_SKIP_EQ  = 4'h1; // compare_skip_if_equal
  localparam logic [3:0]  OP_REG_CMP      = 4'h2; // register_compare
  localparam logic [3:0]  OP_CMP_CARRY    = 4'h3; // compare_with_carry
  localparam logic [3:0]  OP_CMP_IMM      = 4'h4; // compare_immediate
  localparam logic [3:0]  OP_SKIP_RB_CLR  = 4'h5; // skip_reg_bit_clear
  localparam logic [3:0]  OP_SKIP_RB_SET  = 4'h6; // skip_reg_bit_set
  localparam logic [3:0]  OP_SKIP_IO_CLR  = 4'h7; // skip_io_bit_clear
  localparam logic [3:0]  OP_SKIP_IO_SET  = 4'h8; // skip_io_bit_set
  localparam logic [3:0]  OP_BR_SET       = 4'h9; // branch_status_bit_set
  localparam logic [3:0]  OP_BR_CLR       = 4'hA; // branch_status_bit_clear
  localparam logic [3:0]  OP_CALL         = 4'hB; // direct call, two words
  localparam logic [3:0]  OP_RETURN       = 4'hC; // bit 0 set: interrupt_return
  localparam logic [3:0]  OP_JUMP_LONG    = 4'hD; // two-word jump, run elsewhere

  // Status flag bit positions
  localparam int          FLAG_C      = 0;
  localparam int          FLAG_Z      = 1;
  localparam int          FLAG_N      = 2;
  localparam int          FLAG_V      = 3;
  localparam int          FLAG_S      = 4;
  localparam int          FLAG_H      = 5;
  localparam int          FLAG_T      = 6;
  localparam int          FLAG_I      = 7;
  localparam logic [7:0]  FLAGS_RESET = 8'h00;

  // APB register byte offsets
  localparam logic [7:0]  ADDR_FLAGS  = 8'h00;
  localparam logic [7:0]  ADDR_PC     = 8'h04;
  localparam logic [7:0]  ADDR_CTRL   = 8'h08;
  localparam logic [7:0]  ADDR_SP     = 8'h0C;
  localparam int          CTRL_RUN    = 0;
  localparam logic        RUN_RESET   = 1'b0;

  typedef enum logic [2:0] {
    ST_EXEC     = 3'b000,
    ST_SKIP     = 3'b001,
    ST_SKIP2    = 3'b010,
    ST_BRANCH   = 3'b011,
    ST_CALL     = 3'b100,
    ST_RET_POP  = 3'b101,
    ST_RET_LOAD = 3'b110,
    ST_RET_END  = 3'b111
  } exec_state_t;

endpackage

// *** design/return_stack_mem.sv ***
// Purpose: Return address storage with registered read data
// Assumes: One write and one read port, same clock
// Notes:   Contents are not reset; only the read register is
module return_stack_mem #(
  parameter int DEPTH = 16,
  parameter int WIDTH = 16
) (
  input  wire logic                     clock,    // core clock
  input  wire logic                     reset,    // async, active high
  input  wire logic                     wr_en,    // push strobe
  input  wire logic [$clog2(DEPTH)-1:0] wr_addr,  // push slot
  input  wire logic [WIDTH-1:0]         wr_data,  // return address in
  input  wire logic                     rd_en,    // pop strobe
  input  wire logic [$clog2(DEPTH)-1:0] rd_addr,  // pop slot
  output logic      [WIDTH-1:0]         rd_data_r // return address out
);

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rd_data_r <= '0;
    end else if (rd_en) begin
      rd_data_r <= mem[rd_addr];
    end
  end

endmodule // return_stack_mem

// *** design/compare_skip_branch_unit.sv ***
// Purpose: Executes compare, skip, relative branch, call and return words
// Assumes: Instruction, register and I/O data valid in the cycle addressed
// Notes:   Other opcodes just advance the program counter by their length
module compare_skip_branch_unit
  import cbu_pkg::*;
#(
  parameter int PC_W        = 16,
  parameter int STACK_DEPTH = 16
) (
  input  wire logic               clock,       // core clock, 100 MHz
  input  wire logic               reset,       // async, active high
  output logic      [PC_W-1:0]    pc_r,        // fetch address
  input  wire logic [INSTR_W-1:0] instr,       // word at pc_r
  output logic      [4:0]         rf_addr_a,   // first register operand
  output logic      [4:0]         rf_addr_b,   // second register operand
  input  wire logic [DATA_W-1:0]  rf_data_a,   // first operand value
  input  wire logic [DATA_W-1:0]  rf_data_b,   // second operand value
  output logic      [4:0]         io_addr,     // I/O register address
  input  wire logic [DATA_W-1:0]  io_data,     // I/O register value
  output logic      [7:0]         flags_r,     // status flags
  input  wire logic               psel,        // APB select
  input  wire logic               penable,     // APB enable
  input  wire logic               pwrite,      // APB direction
  input  wire logic [7:0]         paddr,       // APB byte address
  input  wire logic [31:0]        pwdata,      // APB write data
  output logic      [31:0]        prdata,      // APB read data
  output logic                    pready,      // APB ready
  output logic                    pslverr      // APB error
);

  localparam int SP_W = $clog2(STACK_DEPTH);

  // The call target is taken from one instruction word, so PC_W cannot exceed it
  if (PC_W < 8 || PC_W > INSTR_W) begin : g_pc_check
    $error("PC_W must lie between 8 and INSTR_W");
  end
  if (STACK_DEPTH < 2 || (1 << SP_W) != STACK_DEPTH) begin : g_depth_check
    $error("STACK_DEPTH must be a power of two of at least 2");
  end

  exec_state_t        state_r;
  logic               run_r;
  logic [SP_W:0]      sp_r;
  logic [31:0]        prdata_r;
  logic [PC_W-1:0]    stack_rd_data;

  // Decode
  logic [3:0]         op;
  logic               exec_go;
  logic               two_word;
  logic               is_cmp;
  logic [DATA_W-1:0]  opnd_b;
  logic               carry_in;
  logic [DATA_W:0]    diff;
  logic [DATA_W-1:0]  res;
  logic               res_zero;
  logic               reg_bit;
  logic               io_bit;
  logic               skip_hit;
  logic               br_flag;
  logic               br_taken;
  logic [PC_W-1:0]    br_target;
  logic [7:0]         cmp_flags;
  logic               push_en;
  logic               pop_en;
  logic               stack_full;
  logic               stack_empty;
  logic               apb_setup;
  logic               apb_wr;
  logic               addr_ok;

  assign op        = instr[15:12];
  assign exec_go   = (state_r == ST_EXEC) && run_r;
  assign two_word  = (op == OP_CALL) || (op == OP_JUMP_LONG);
  assign is_cmp    = (op == OP_REG_CMP) || (op == OP_CMP_CARRY) || (op == OP_CMP_IMM);

  always_comb begin
    if (op == OP_CMP_IMM) begin
      rf_addr_a = {1'b1, instr[11:8]};
    end else if (op == OP_SKIP_RB_CLR || op == OP_SKIP_RB_SET) begin
      rf_addr_a = instr[8:4];
    end else begin
      rf_addr_a = instr[9:5];
    end
  end
  assign rf_addr_b = instr[4:0];
  assign io_addr   = instr[7:3];

  // Subtract with no write-back; carry variant also takes C
  assign opnd_b    = (op == OP_CMP_IMM) ? instr[7:0] : rf_data_b;
  assign carry_in  = (op == OP_CMP_CARRY) ? flags_r[FLAG_C] : 1'b0;
  assign diff      = {1'b0, rf_data_a} - {1'b0, opnd_b} - {{DATA_W{1'b0}}, carry_in};
  assign res       = diff[DATA_W-1:0];
  assign res_zero  = (res == '0);

  always_comb begin
    cmp_flags          = flags_r;
    cmp_flags[FLAG_H]  = (~rf_data_a[3] & opnd_b[3]) | (opnd_b[3] & res[3])
                       | (res[3] & ~rf_data_a[3]);
    cmp_flags[FLAG_V]  = (rf_data_a[7] & ~opnd_b[7] & ~res[7])
                       | (~rf_data_a[7] & opnd_b[7] & res[7]);
    cmp_flags[FLAG_N]  = res[7];
    cmp_flags[FLAG_S]  = res[7] ^ cmp_flags[FLAG_V];
    cmp_flags[FLAG_C]  = (~rf_data_a[7] & opnd_b[7]) | (opnd_b[7] & res[7])
                       | (res[7] & ~rf_data_a[7]);
    // Carry variant keeps Z only if it was already set, for multi-byte chains
    cmp_flags[FLAG_Z]  = (op == OP_CMP_CARRY) ? (res_zero & flags_r[FLAG_Z]) : res_zero;
  end

  assign reg_bit = rf_data_a[instr[2:0]];
  assign io_bit  = io_data[instr[2:0]];

  always_comb begin
    case (op)
      OP_CMP_SKIP_EQ: skip_hit = (rf_data_a == rf_data_b);
      OP_SKIP_RB_CLR: skip_hit = ~reg_bit;
      OP_SKIP_RB_SET: skip_hit = reg_bit;
      OP_SKIP_IO_CLR: skip_hit = ~io_bit;
      OP_SKIP_IO_SET: skip_hit = io_bit;
      default:        skip_hit = 1'b0;
    endcase
  end

  // Equal, not-equal and carry branches are the status forms on Z and C
  assign br_flag   = flags_r[instr[2:0]];
  assign br_taken  = (op == OP_BR_SET) ? br_flag
                   : (op == OP_BR_CLR) ? ~br_flag : 1'b0;
  assign br_target = pc_r + {{(PC_W-7){instr[9]}}, instr[9:3]} + PC_W'(1);

  assign stack_full  = sp_r[SP_W];
  assign stack_empty = (sp_r == '0);
  assign push_en     = (state_r == ST_CALL) && !stack_full;
  assign pop_en      = exec_go && (op == OP_RETURN) && !stack_empty;

  return_stack_mem #(
    .DEPTH (STACK_DEPTH),
    .WIDTH (PC_W)
  ) u_stack (
    .clock     (clock),
    .reset     (reset),
    .wr_en     (push_en),
    .wr_addr   (sp_r[SP_W-1:0]),
    .wr_data   (pc_r + PC_W'(1)),
    .rd_en     (pop_en),
    .rd_addr   (SP_W'(sp_r - 1'b1)),
    .rd_data_r (stack_rd_data)
  );

  // Sequencer
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_r <= ST_EXEC;
    end else begin
      case (state_r)
        ST_EXEC: begin
          if (!run_r) begin
            state_r <= ST_EXEC;
          end else if (skip_hit) begin
            state_r <= ST_SKIP;
          end else if (br_taken) begin
            state_r <= ST_BRANCH;
          end else if (op == OP_CALL) begin
            state_r <= ST_CALL;
          end else if (op == OP_RETURN) begin
            state_r <= ST_RET_POP;
          end
        end
        ST_SKIP:     state_r <= two_word ? ST_SKIP2 : ST_EXEC;
        ST_RET_POP:  state_r <= ST_RET_LOAD;
        ST_RET_LOAD: state_r <= ST_RET_END;
        default:     state_r <= ST_EXEC;
      endcase
    end
  end

  // Program counter
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      pc_r <= '0;
    end else begin
      case (state_r)
        ST_EXEC: begin
          if (!run_r || op == OP_RETURN) begin
            pc_r <= pc_r;
          end else if (br_taken) begin
            pc_r <= br_target;
          end else if (op == OP_JUMP_LONG) begin
            // A call steps one word only, onto its target word for ST_CALL
            pc_r <= pc_r + PC_W'(2);
          end else begin
            pc_r <= pc_r + PC_W'(1);
          end
        end
        ST_SKIP, ST_SKIP2: pc_r <= pc_r + PC_W'(1);
        ST_CALL:           pc_r <= instr[PC_W-1:0];
        ST_RET_POP:        pc_r <= stack_rd_data;
        default:           pc_r <= pc_r;
      endcase
    end
  end

  // Call enters ST_CALL with pc_r already on its target word
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      sp_r <= '0;
    end else if (push_en) begin
      sp_r <= sp_r + 1'b1;
    end else if (pop_en) begin
      sp_r <= sp_r - 1'b1;
    end
  end

  // APB slave: zero wait states, read data captured in the setup cycle
  assign apb_setup = psel && !penable;
  assign apb_wr    = psel && penable && pwrite;
  assign addr_ok   = (paddr == ADDR_FLAGS) || (paddr == ADDR_PC)
                   || (paddr == ADDR_CTRL) || (paddr == ADDR_SP);
  assign pready    = 1'b1;
  assign pslverr   = psel && penable && !addr_ok;
  assign prdata    = prdata_r;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      prdata_r <= '0;
    end else if (apb_setup && !pwrite) begin
      case (paddr)
        ADDR_FLAGS: prdata_r <= {24'h000000, flags_r};
        ADDR_PC:    prdata_r <= 32'(pc_r);
        ADDR_CTRL:  prdata_r <= {31'h00000000, run_r};
        ADDR_SP:    prdata_r <= 32'(sp_r);
        default:    prdata_r <= '0;
      endcase
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      run_r <= RUN_RESET;
    end else if (apb_wr && paddr == ADDR_CTRL) begin
      run_r <= pwdata[CTRL_RUN];
    end
  end

  // Hardware flag updates win over a software write in the same cycle
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      flags_r <= FLAGS_RESET;
    end else if (exec_go && is_cmp) begin
      flags_r <= cmp_flags;
    end else if (exec_go && op == OP_RETURN && instr[0]) begin
      flags_r[FLAG_I] <= 1'b1;
    end else if (apb_wr && paddr == ADDR_FLAGS) begin
      flags_r <= pwdata[7:0];
    end
  end

  // Checks
  cmp_flags_a: assert property (@(posedge clock) disable iff (reset)
    exec_go && op == OP_REG_CMP |=> flags_r[FLAG_Z] == $past(rf_data_a == rf_data_b))
    else $error("compare zero flag wrong");
  cmp_carry_a: assert property (@(posedge clock) disable iff (reset)
    exec_go && op == OP_CMP_IMM |=> flags_r[FLAG_C] == $past(rf_data_a < instr[7:0]))
    else $error("compare carry flag wrong");
  eq_skip_a: assert property (@(posedge clock) disable iff (reset)
    exec_go && op == OP_CMP_SKIP_EQ && rf_data_a == rf_data_b && !apb_wr
    |=> state_r == ST_SKIP && pc_r == $past(pc_r) + PC_W'(1) && $stable(flags_r))
    else $error("equal compare did not skip");
  reg_clr_a: assert property (@(posedge clock) disable iff (reset)
    exec_go && op == OP_SKIP_RB_CLR |=> (state_r == ST_SKIP) == !$past(reg_bit))
    else $error("register bit clear skip wrong");
  reg_set_a: assert property (@(posedge clock) disable iff (reset)
    exec_go && op == OP_SKIP_RB_SET |=> (state_r == ST_SKIP) == $past(reg_bit))
    else $error("register bit set skip wrong");
  io_clr_a: assert property (@(posedge clock) disable iff (reset)
    exec_go && op == OP_SKIP_IO_CLR |=> (state_r == ST_SKIP) == !$past(io_bit))
    else $error("I/O bit clear skip wrong");
  io_set_a: assert property (@(posedge clock) disable iff (reset)
    exec_go && op == OP_SKIP_IO_SET |=> (state_r == ST_SKIP) == $past(io_bit))
    else $error("I/O bit set skip wrong");
  br_set_a: assert property (@(posedge clock) disable iff (reset)
    exec_go && op == OP_BR_SET && br_flag
    |=> pc_r == $past(br_target) && state_r == ST_BRANCH ##1 state_r == ST_EXEC)
    else $error("status set branch wrong");
  br_clr_a: assert property (@(posedge clock) disable iff (reset)
    exec_go && op == OP_BR_CLR && br_flag |=> pc_r == $past(pc_r) + PC_W'(1))
    else $error("status clear branch taken on set bit");
  br_eq_a: assert property (@(posedge clock) disable iff (reset)
    exec_go && op == OP_BR_SET && instr[2:0] == 3'(FLAG_Z) && flags_r[FLAG_Z]
    |=> pc_r == $past(br_target))
    else $error("equal branch not taken");
  br_ne_a: assert property (@(posedge clock) disable iff (reset)
    exec_go && op == OP_BR_CLR && instr[2:0] == 3'(FLAG_Z) && !flags_r[FLAG_Z]
    |=> pc_r == $past(br_target))
    else $error("not-equal branch not taken");
  br_cs_a: assert property (@(posedge clock) disable iff (reset)
    exec_go && op == OP_BR_SET && instr[2:0] == 3'(FLAG_C) && flags_r[FLAG_C]
    |=> pc_r == $past(br_target))
    else $error("carry branch not taken");
  ret_load_a: assert property (@(posedge clock) disable iff (reset)
    pop_en |=> state_r == ST_RET_POP ##1 pc_r == $past(stack_rd_data) ##2 state_r == ST_EXEC)
    else $error("return did not reload pc");
  interrupt_return_flag_a: assert property (@(posedge clock) disable iff (reset)
    exec_go && op == OP_RETURN && instr[0] |=> flags_r[FLAG_I])
    else $error("interrupt return left I clear");
  call_push_a: assert property (@(posedge clock) disable iff (reset)
    push_en |=> pc_r == $past(instr[PC_W-1:0]) && sp_r == $past(sp_r) + 1'b1)
    else $error("call push or load wrong");

  skip_long_c: cover property (@(posedge clock) disable iff (reset) state_r == ST_SKIP2);
  br_taken_c:  cover property (@(posedge clock) disable iff (reset) state_r == ST_BRANCH);
  call_ret_c:  cover property (@(posedge clock) disable iff (reset)
    push_en ##[1:20] state_r == ST_RET_LOAD);
  cmp_carry_c: cover property (@(posedge clock) disable iff (reset)
    exec_go && op == OP_CMP_CARRY && flags_r[FLAG_C]);

endmodule // compare_skip_branch_unit

// *** tb/cbu_partner.sv ***
// Purpose: Program memory, register file and I/O space seen by the unit
// Assumes: Contents are loaded by the bench before reset is released
// Notes:   Reads are combinational; unloaded program words act as no-ops
module cbu_partner
  import cbu_pkg::*;
(
  input  wire logic [15:0]        pc_r,      // fetch address
  output logic      [INSTR_W-1:0] instr,     // word at pc_r
  input  wire logic [4:0]         rf_addr_a, // first operand address
  input  wire logic [4:0]         rf_addr_b, // second operand address
  output logic      [DATA_W-1:0]  rf_data_a, // first operand value
  output logic      [DATA_W-1:0]  rf_data_b, // second operand value
  input  wire logic [4:0]         io_addr,   // I/O address
  output logic      [DATA_W-1:0]  io_data    // I/O value
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [INSTR_W-1:0] prog [0:255];
  logic [DATA_W-1:0]  regs [0:31];
  logic [DATA_W-1:0]  io   [0:31];

  // Upper address bits ignored: the test program stays below 256 words
  assign instr     = prog[pc_r[7:0]];
  assign rf_data_a = regs[rf_addr_a];
  assign rf_data_b = regs[rf_addr_b];
  assign io_data   = io[io_addr];

  initial begin
    for (int i = 0; i < 256; i++) begin
      prog[i] = 16'h0000;
    end
    for (int i = 0; i < 32; i++) begin
      regs[i] = 8'h00;
      io[i]   = 8'h00;
    end
  end
endmodule // cbu_partner

// *** tb/compare_skip_branch_unit_tb.sv ***
// Purpose: Runs one program through the unit and checks pc and flags per cycle
// Assumes: Zero wait-state APB slave; execution begins once run is written
// Notes:   Flag S is masked since its update is not promised by compares
module compare_skip_branch_unit_tb;
  import cbu_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clock, reset, psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, err;
  logic [15:0] pc_r;
  logic [15:0] instr;
  logic [4:0]  rf_addr_a, rf_addr_b, io_addr;
  logic [7:0]  rf_data_a, rf_data_b, io_data, flags_r;
  int          failures, checks;

  // Program as {address, word}
  logic [23:0] prg [] = '{24'h01_4005, 24'h02_9011, 24'h05_1022, 24'h06_4000, 24'h07_2064,
    24'h08_5053, 24'h09_6053, 24'h0A_B000, 24'h0B_0000, 24'h0C_7010, 24'h0D_8010,
    24'h0E_0000, 24'h0F_A008, 24'h10_9018, 24'h14_3064, 24'h15_A009, 24'h17_9011,
    24'h18_B000, 24'h19_0030, 24'h30_C000, 24'h1A_B000, 24'h1B_0040, 24'h40_C001,
    24'h1C_9017};
  // Expected {pc, flags without S} after each edge
  logic [23:0] trace [] = '{24'h0002_02, 24'h0005_02, 24'h0005_02, 24'h0006_02,
    24'h0007_02, 24'h0008_05, 24'h0009_05, 24'h000A_05, 24'h000B_05, 24'h000C_05,
    24'h000D_05, 24'h000E_05, 24'h000F_05, 24'h0010_05, 24'h0014_05, 24'h0014_05,
    24'h0015_25, 24'h0017_25, 24'h0017_25, 24'h0018_25, 24'h0019_25, 24'h0030_25,
    24'h0030_25, 24'h001A_25, 24'h001A_25, 24'h001A_25, 24'h001B_25, 24'h0040_25,
    24'h0040_A5, 24'h001C_A5, 24'h001C_A5, 24'h001C_A5, 24'h001F_A5, 24'h001F_A5,
    24'h0020_A5};

  compare_skip_branch_unit u_compare_skip_branch_unit (
    .clock(clock), .reset(reset), .pc_r(pc_r), .instr(instr), .rf_addr_a(rf_addr_a),
    .rf_addr_b(rf_addr_b), .rf_data_a(rf_data_a), .rf_data_b(rf_data_b),
    .io_addr(io_addr), .io_data(io_data), .flags_r(flags_r), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));

  cbu_partner u_cbu_partner (
    .pc_r(pc_r), .instr(instr), .rf_addr_a(rf_addr_a), .rf_addr_b(rf_addr_b),
    .rf_data_a(rf_data_a), .rf_data_b(rf_data_b), .io_addr(io_addr), .io_data(io_data));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic results();
    if (failures == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Called just after a rising edge; holds the request until pready is seen
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    bit done;
    done = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clock);
    penable <= 1'b1;
    for (int n = 0; n < 20 && !done; n++) begin
      @(posedge clock);
      if (pready === 1'b1) begin
        rd   = prdata;
        err  = pslverr;
        done = 1;
      end
    end
    psel    <= 1'b0;
    penable <= 1'b0;
    // One idle edge, so a following call never reassigns psel in this step
    @(posedge clock);
    if (!done) begin
      failures++;
      results();
    end
  endtask

  initial begin
    reset = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    // The partner clears its memories at time zero; load only after that
    #1;
    foreach (prg[i]) u_cbu_partner.prog[prg[i][23:16]] = prg[i][15:0];
    u_cbu_partner.regs[1]  = 8'h07;
    u_cbu_partner.regs[2]  = 8'h07;
    u_cbu_partner.regs[3]  = 8'h10;
    u_cbu_partner.regs[4]  = 8'h20;
    u_cbu_partner.regs[5]  = 8'h08;
    u_cbu_partner.regs[16] = 8'h05;
    u_cbu_partner.io[2]    = 8'h01;
    repeat (10) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    apb(1'b1, ADDR_FLAGS, 32'h0000_005A);
    apb(1'b0, ADDR_FLAGS, 32'h0);
    check(rd, 32'h0000_005A);
    apb(1'b0, 8'h10, 32'h0);
    check({rd[30:0], err}, 32'h0000_0001);
    apb(1'b1, ADDR_FLAGS, 32'h0);
    apb(1'b1, ADDR_CTRL, 32'h0000_0001);
    // The task returns on the edge that executes address 0; let pc settle
    #1;
    // The no-op at address 0 marks where execution starts
    for (int n = 0; n <= 20 && pc_r !== 16'h0001; n++) begin
      if (n == 20) begin
        failures++;
        results();
      end
      @(posedge clock);
      #1;
    end
    foreach (trace[i]) begin
      @(posedge clock);
      #1;
      check({8'h00, pc_r, flags_r & 8'hEF}, {8'h00, trace[i]});
    end
    @(posedge clock);
    apb(1'b0, ADDR_FLAGS, 32'h0);
    check(rd & 32'hFFFF_FFEF, 32'h0000_00A5);
    apb(1'b0, ADDR_SP, 32'h0);
    check(rd, 32'h0000_0000);
    apb(1'b0, ADDR_CTRL, 32'h0);
    check(rd, 32'h0000_0001);
    results();
  end
endmodule // compare_skip_branch_unit_tb
